// *** core/adccc_map.vh ***
`ifndef ADCCC_MAP_VH
`define ADCCC_MAP_VH
// Register byte addresses
`define ADCCC_CTRL_A_ADDR 12'h000
`define ADCCC_CTRL_B_ADDR 12'h004
`define ADCCC_CTRL_C_ADDR 12'h008
`define ADCCC_RES_HI_ADDR 12'h00C
`define ADCCC_RES_LO_ADDR 12'h010
`define ADCCC_PIN_SEL_ADDR 12'h014
`define ADCCC_INT_CTRL_ADDR 12'h018
// Control A fields
`define ADCCC_A_START 7
`define ADCCC_A_BUSY 6
`define ADCCC_A_PWR 5
`define ADCCC_A_ALIGN 4
// Control B fields
`define ADCCC_B_SRC_HI 7
`define ADCCC_B_SRC_LO 4
`define ADCCC_B_CKDIV_HI 2
// Control C fields
`define ADCCC_C_REF_HI 3
`define ADCCC_C_REF_LO 2
// Interrupt control fields
`define ADCCC_I_GIE 0
`define ADCCC_I_CIE 1
`define ADCCC_I_REQ 2
// Reset values
`define ADCCC_CTRL_A_RST 8'h00
`define ADCCC_CTRL_B_RST 8'h00
`define ADCCC_CTRL_C_RST 8'h00
`define ADCCC_PIN_SEL_RST 8'h00
// Timing
`define ADCCC_CONV_CYCLES 5'h10
`define ADCCC_PWRUP_NS 1000
`define ADCCC_CLK_NS 40
`define ADCCC_PWRUP_CYC ((`ADCCC_PWRUP_NS + `ADCCC_CLK_NS - 1) / `ADCCC_CLK_NS)
`endif

// *** core/adccc_clkdiv.v ***
`timescale 1ns/1ps
// Power-of-two conversion clock tick generator
module adccc_clkdiv (
  input wire clock,
  input wire reset_n,
  input wire clear,
  input wire [2:0] div_sel,
  output reg tick
);
  reg [6:0] cnt_r;
  wire [6:0] mask;
  assign mask = (7'h01 << div_sel) - 7'h01;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 7'h00;
      tick <= 1'b0;
    end else if (clear) begin
      cnt_r <= 7'h00;
      tick <= 1'b0;
    end else begin
      tick <= ((cnt_r & mask) == mask);
      cnt_r <= cnt_r + 7'h01;
    end
  end
endmodule

// *** core/adccc_mux.v ***
`timescale 1ns/1ps
// Input and reference routing decode
module adccc_mux (
  input wire clock,
  input wire reset_n,
  input wire [3:0] src_sel,
  input wire [3:0] chan_sel,
  input wire [1:0] ref_sel,
  input wire [3:0] pin_analog,
  output reg [3:0] chan_on,
  output reg [5:0] int_sel,
  output reg gnd_sel,
  output reg [2:0] ref_route,
  output reg ext_path
);
  function is_ext;
    input [3:0] s;
    begin
      is_ext = (s == 4'h0) || (s == 4'h4) || (s[3:2] == 2'b11);
    end
  endfunction
  reg ext;
  always @* begin
    ext = is_ext(src_sel);
  end
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      chan_on <= 4'h0;
      int_sel <= 6'h00;
      gnd_sel <= 1'b0;
      ref_route <= 3'h0;
      ext_path <= 1'b0;
    end else begin
      ext_path <= ext;
      chan_on <= (ext && chan_sel[3:2] == 2'b00) ?
        ((4'h1 << chan_sel[1:0]) & pin_analog) : 4'h0;
      int_sel[0] <= (src_sel == 4'h2);
      int_sel[1] <= (src_sel == 4'h3);
      int_sel[2] <= (src_sel == 4'h5);
      int_sel[3] <= (src_sel == 4'h6);
      int_sel[4] <= (src_sel == 4'h7);
      int_sel[5] <= (src_sel == 4'h8);
      gnd_sel <= (src_sel >= 4'h9) && (src_sel <= 4'hB);
      ref_route[0] <= (ref_sel == 2'b00);
      ref_route[1] <= (ref_sel == 2'b01);
      ref_route[2] <= ref_sel[1];
    end
  end
endmodule

// *** core/adccc_top.v ***
`timescale 1ns/1ps
`include "adccc_map.vh"
module adccc_top (
  input wire clock,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [11:0] conv_data,
  input wire [3:0] port_dir_in,
  input wire [3:0] port_pullup_en,
  output reg conv_power,
  output reg conv_sample,
  output reg conv_run,
  output reg [3:0] chan_on,
  output reg [5:0] int_sel,
  output reg gnd_sel,
  output reg ext_path,
  output reg [2:0] ref_route,
  output reg [3:0] pin_analog,
  output reg [3:0] pin_dir_eff,
  output reg [3:0] pin_pullup_eff,
  output reg cpu_irq
);
  localparam S_IDLE = 3'b001;
  localparam S_ARM = 3'b010;
  localparam S_CONV = 3'b100;

  reg [7:0] ctrl_a_r;
  reg [7:0] ctrl_b_r;
  reg [7:0] ctrl_c_r;
  reg [7:0] pin_sel_r;
  reg [7:0] res_hi_r;
  reg [7:0] res_lo_r;
  reg gie_r;
  reg cie_r;
  reg req_r;
  reg busy_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [4:0] tick_cnt_r;
  reg [7:0] pwr_cnt_r;
  reg pwr_ready_r;
  wire ck_tick;
  wire done;
  wire wr_en;
  wire rd_en;
  wire [3:0] m_chan_on;
  wire [5:0] m_int_sel;
  wire m_gnd;
  wire [2:0] m_ref;
  wire m_ext;

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign done = (state_r == S_CONV) && ck_tick &&
    (tick_cnt_r == `ADCCC_CONV_CYCLES - 5'h01);

  function addr_ok;
    input [11:0] a;
    begin
      addr_ok = (a == `ADCCC_CTRL_A_ADDR) || (a == `ADCCC_CTRL_B_ADDR) ||
        (a == `ADCCC_CTRL_C_ADDR) || (a == `ADCCC_RES_HI_ADDR) ||
        (a == `ADCCC_RES_LO_ADDR) || (a == `ADCCC_PIN_SEL_ADDR) ||
        (a == `ADCCC_INT_CTRL_ADDR);
    end
  endfunction

  adccc_clkdiv u_div (
    .clock(clock),
    .reset_n(reset_n),
    .clear(state_r != S_CONV),
    .div_sel(ctrl_b_r[`ADCCC_B_CKDIV_HI:0]),
    .tick(ck_tick)
  );

  adccc_mux u_mux (
    .clock(clock),
    .reset_n(reset_n),
    .src_sel(ctrl_b_r[`ADCCC_B_SRC_HI:`ADCCC_B_SRC_LO]),
    .chan_sel(ctrl_a_r[3:0]),
    .ref_sel(ctrl_c_r[`ADCCC_C_REF_HI:`ADCCC_C_REF_LO]),
    .pin_analog(pin_sel_r[3:0]),
    .chan_on(m_chan_on),
    .int_sel(m_int_sel),
    .gnd_sel(m_gnd),
    .ref_route(m_ref),
    .ext_path(m_ext)
  );

  // Sequencer
  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (ctrl_a_r[`ADCCC_A_START])
          state_nxt = S_ARM;
      end
      S_ARM: begin
        if (!ctrl_a_r[`ADCCC_A_START]) begin
          if (ctrl_a_r[`ADCCC_A_PWR] && pwr_ready_r)
            state_nxt = S_CONV;
          else
            state_nxt = S_IDLE;
        end
      end
      S_CONV: begin
        if (ctrl_a_r[`ADCCC_A_START] || !ctrl_a_r[`ADCCC_A_PWR])
          state_nxt = S_IDLE;
        else if (done)
          state_nxt = S_IDLE;
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= S_IDLE;
      tick_cnt_r <= 5'h00;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r != S_CONV)
        tick_cnt_r <= 5'h00;
      else if (ck_tick)
        tick_cnt_r <= tick_cnt_r + 5'h01;
      busy_r <= (state_nxt == S_CONV);
    end
  end

  // Power-up delay counter
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pwr_cnt_r <= 8'h00;
      pwr_ready_r <= 1'b0;
    end else if (!ctrl_a_r[`ADCCC_A_PWR]) begin
      pwr_cnt_r <= 8'h00;
      pwr_ready_r <= 1'b0;
    end else if (pwr_cnt_r == `ADCCC_PWRUP_CYC - 1) begin
      pwr_ready_r <= 1'b1;
    end else begin
      pwr_cnt_r <= pwr_cnt_r + 8'h01;
    end
  end

  // Register writes, result capture and request flag
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_a_r <= `ADCCC_CTRL_A_RST;
      ctrl_b_r <= `ADCCC_CTRL_B_RST;
      ctrl_c_r <= `ADCCC_CTRL_C_RST;
      pin_sel_r <= `ADCCC_PIN_SEL_RST;
      res_hi_r <= 8'h00;
      res_lo_r <= 8'h00;
      gie_r <= 1'b0;
      cie_r <= 1'b0;
      req_r <= 1'b0;
    end else begin
      if (wr_en && paddr == `ADCCC_CTRL_A_ADDR)
        ctrl_a_r <= {pwdata[7], 1'b0, pwdata[5:0]};
      if (wr_en && paddr == `ADCCC_CTRL_B_ADDR)
        ctrl_b_r <= {pwdata[7:4], 1'b0, pwdata[2:0]};
      if (wr_en && paddr == `ADCCC_CTRL_C_ADDR)
        ctrl_c_r <= {pwdata[7], 2'b00, pwdata[4:0]};
      if (wr_en && paddr == `ADCCC_PIN_SEL_ADDR)
        pin_sel_r <= {4'h0, pwdata[3:0]};
      if (wr_en && paddr == `ADCCC_INT_CTRL_ADDR) begin
        gie_r <= pwdata[`ADCCC_I_GIE];
        cie_r <= pwdata[`ADCCC_I_CIE];
      end
      // Set wins over software write
      if (done)
        req_r <= 1'b1;
      else if (wr_en && paddr == `ADCCC_INT_CTRL_ADDR)
        req_r <= pwdata[`ADCCC_I_REQ];
      // Result only updated on completion, so held while off
      if (done) begin
        if (ctrl_a_r[`ADCCC_A_ALIGN]) begin
          res_hi_r <= {4'h0, conv_data[11:8]};
          res_lo_r <= conv_data[7:0];
        end else begin
          res_hi_r <= conv_data[11:4];
          res_lo_r <= {conv_data[3:0], 4'h0};
        end
      end
    end
  end

  // APB slave, zero wait states
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok(paddr);
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `ADCCC_CTRL_A_ADDR:
            prdata <= {24'h0, ctrl_a_r[7], busy_r, ctrl_a_r[5:0]};
          `ADCCC_CTRL_B_ADDR: prdata <= {24'h0, ctrl_b_r};
          `ADCCC_CTRL_C_ADDR: prdata <= {24'h0, ctrl_c_r};
          `ADCCC_RES_HI_ADDR: prdata <= {24'h0, res_hi_r};
          `ADCCC_RES_LO_ADDR: prdata <= {24'h0, res_lo_r};
          `ADCCC_PIN_SEL_ADDR: prdata <= {24'h0, pin_sel_r};
          `ADCCC_INT_CTRL_ADDR:
            prdata <= {29'h0, req_r, cie_r, gie_r};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Analog-side, pin and interrupt outputs
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      conv_power <= 1'b0;
      conv_sample <= 1'b0;
      conv_run <= 1'b0;
      chan_on <= 4'h0;
      int_sel <= 6'h00;
      gnd_sel <= 1'b0;
      ext_path <= 1'b0;
      ref_route <= 3'h0;
      pin_analog <= 4'h0;
      pin_dir_eff <= 4'h0;
      pin_pullup_eff <= 4'h0;
      cpu_irq <= 1'b0;
    end else begin
      conv_power <= ctrl_a_r[`ADCCC_A_PWR];
      conv_run <= busy_r;
      conv_sample <= busy_r && (tick_cnt_r < 5'h04);
      chan_on <= m_chan_on;
      int_sel <= m_int_sel;
      gnd_sel <= m_gnd;
      ext_path <= m_ext;
      ref_route <= m_ref;
      pin_analog <= pin_sel_r[3:0];
      pin_dir_eff <= port_dir_in | pin_sel_r[3:0];
      pin_pullup_eff <= port_pullup_en & ~pin_sel_r[3:0];
      cpu_irq <= req_r & cie_r & gie_r;
    end
  end
endmodule

// *** tb/adccc_asserts.sv ***
`timescale 1ns/1ps
module adccc_asserts (
  input wire clock,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire [3:0] port_dir_in,
  input wire [3:0] port_pullup_en,
  input wire conv_power,
  input wire conv_run,
  input wire [3:0] chan_on,
  input wire [5:0] int_sel,
  input wire gnd_sel,
  input wire ext_path,
  input wire [2:0] ref_route,
  input wire [3:0] pin_analog,
  input wire [3:0] pin_dir_eff,
  input wire [3:0] pin_pullup_eff
);
  reg [1:0] up_r;
  // Masks the first edges after reset
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      up_r <= 2'h0;
    end else if (up_r != 2'h3) begin
      up_r <= up_r + 2'h1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  chk_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready too long");
  chk_ref_onehot: assert property (up_r == 2'h3 |-> $onehot(ref_route))
    else $error("reference route");
  chk_chan_onehot: assert property ($onehot0(chan_on))
    else $error("channel route");
  chk_int_excl: assert property (|int_sel |->
    $onehot(int_sel) && chan_on == 4'h0 && !ext_path) else $error("int mix");
  chk_gnd_excl: assert property (gnd_sel |->
    chan_on == 4'h0 && int_sel == 6'h00) else $error("ground mix");
  chk_pull_drop: assert property ((up_r == 2'h3 && $stable(pin_analog))
    ##1 $stable(pin_analog) |-> pin_pullup_eff == (port_pullup_en &
    ~pin_analog)) else $error("pull-high kept");
  chk_dir_over: assert property ((up_r == 2'h3 && $stable(pin_analog))
    ##1 $stable(pin_analog) |-> pin_dir_eff == (port_dir_in | pin_analog))
    else $error("direction kept");
  chk_conv_len: assert property ($fell(conv_run) && conv_power &&
    up_r == 2'h3 |-> $past(conv_run, 15)) else $error("short conversion");
endmodule
bind adccc_top adccc_asserts adccc_asserts_i (.clock(clock),
  .reset_n(reset_n), .psel(psel), .penable(penable), .pready(pready),
  .port_dir_in(port_dir_in), .port_pullup_en(port_pullup_en),
  .conv_power(conv_power), .conv_run(conv_run), .chan_on(chan_on),
  .int_sel(int_sel), .gnd_sel(gnd_sel), .ext_path(ext_path),
  .ref_route(ref_route), .pin_analog(pin_analog),
  .pin_dir_eff(pin_dir_eff), .pin_pullup_eff(pin_pullup_eff));

// *** tb/adccc_core_model.sv ***
`timescale 1ns/1ps
module adccc_core_model #(
  parameter [11:0] RESULT = 12'hA5C
) (
  input wire clock,
  input wire reset_n,
  input wire conv_power,
  input wire conv_run,
  output reg [11:0] conv_data
);
  // Holds the sample through a run, toggles junk otherwise
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      conv_data <= ~RESULT;
    end else if (conv_power && conv_run) begin
      conv_data <= RESULT;
    end else begin
      conv_data <= ~conv_data;
    end
  end
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
`include "adccc_map.vh"
module tb;
  localparam [11:0] ra = `ADCCC_CTRL_A_ADDR;
  localparam [11:0] rb = `ADCCC_CTRL_B_ADDR;
  localparam [11:0] rh = `ADCCC_RES_HI_ADDR;
  localparam [11:0] ri = `ADCCC_INT_CTRL_ADDR;
  reg clock = 1'b0;
  reg reset_n = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire [11:0] conv_data;
  wire pready, pslverr, conv_power, conv_sample, conv_run;
  wire gnd_sel, ext_path, cpu_irq;
  wire [3:0] chan_on, pin_analog, pin_dir_eff, pin_pullup_eff;
  wire [5:0] int_sel;
  wire [2:0] ref_route;
  integer fails = 0;
  integer checked = 0;
  integer i;
  reg [31:0] rd;
  reg err;
  always #20 clock = ~clock;
  adccc_top adccc_top_i (.clock(clock), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_data(conv_data), .port_dir_in(4'h3), .port_pullup_en(4'hF),
    .conv_power(conv_power), .conv_sample(conv_sample),
    .conv_run(conv_run), .chan_on(chan_on), .int_sel(int_sel),
    .gnd_sel(gnd_sel), .ext_path(ext_path), .ref_route(ref_route),
    .pin_analog(pin_analog), .pin_dir_eff(pin_dir_eff),
    .pin_pullup_eff(pin_pullup_eff), .cpu_irq(cpu_irq));
  adccc_core_model adccc_core_model_i (.clock(clock), .reset_n(reset_n),
    .conv_power(conv_power), .conv_run(conv_run), .conv_data(conv_data));
  task close_out;
    begin
      $display("fails=%0d checked=%0d", fails, checked);
      if (fails == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      @(posedge clock);
      while (pready !== 1'b1 && n < 50) begin
        @(posedge clock);
        n = n + 1;
      end
      if (n == 50) begin
        fails = fails + 1;
        close_out;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  function [11:0] route_exp(input [3:0] s);
    reg e;
    begin
      e = s == 4'h0 || s == 4'h4 || s >= 4'hC;
      route_exp = {e ? 4'h1 << s[1:0] : 4'h0, 6'h00, s >= 4'h9 && s <= 4'hB, e};
      if (s == 4'h2 || s == 4'h3) route_exp[s] = 1'b1;
      if (s >= 4'h5 && s <= 4'h8) route_exp[s - 4'h1] = 1'b1;
    end
  endfunction
  task t_regs;
    for (i = 0; i < 8; i = i + 1) begin
      if (i != 3 && i != 4) begin
        apb(1'b0, 12'(i * 4), 32'h0);
        cmp(rd, 32'h0);
        cmp(err, i == 7);
      end
    end
  endtask
  task t_route;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        apb(1'b1, `ADCCC_CTRL_C_ADDR, 32'(i * 4));
        repeat (3) @(posedge clock);
        cmp(ref_route, i == 0 ? 1 : (i == 1 ? 2 : 4));
      end
      apb(1'b1, `ADCCC_PIN_SEL_ADDR, 32'h5);
      repeat (3) @(posedge clock);
      cmp({pin_dir_eff, pin_pullup_eff}, 32'h7A);
      for (i = 0; i < 16; i = i + 1) begin
        apb(1'b1, `ADCCC_PIN_SEL_ADDR,
          (i == 0 || i == 4 || i >= 12) ? 32'hF : 32'h0);
        apb(1'b1, ra, 32'(i % 4));
        apb(1'b1, rb, 32'(i * 16));
        repeat (3) @(posedge clock);
        cmp({chan_on, int_sel, gnd_sel, ext_path}, route_exp(4'(i)));
      end
      $display("routing test done");
    end
  endtask
  task t_conv(input [31:0] al);
    begin
      apb(1'b1, rb, 32'h4);
      apb(1'b1, ra, 32'h20 + al * 16);
      apb(1'b1, `ADCCC_PIN_SEL_ADDR, 32'h1);
      repeat (26) @(posedge clock);
      apb(1'b1, ri, 32'h3);
      apb(1'b1, ra, 32'hA0 + al * 16);
      apb(1'b1, ra, 32'h20 + al * 16);
      apb(1'b0, ra, 32'h0);
      cmp(rd[6], 1);
      cmp({conv_power, conv_sample}, 32'h3);
      repeat (200) @(posedge clock);
      apb(1'b0, ra, 32'h0);
      cmp(rd[6], 1);
      repeat (60) @(posedge clock);
      apb(1'b0, ra, 32'h0);
      cmp(rd[6], 0);
      cmp({conv_power, conv_sample}, 32'h2);
      cmp(cpu_irq, 1);
      apb(1'b0, ri, 32'h0);
      cmp(rd, 32'h7);
      apb(1'b0, rh, 32'h0);
      cmp(rd, al ? 32'h0A : 32'hA5);
      apb(1'b0, `ADCCC_RES_LO_ADDR, 32'h0);
      cmp(rd, al ? 32'h5C : 32'hC0);
      apb(1'b1, ri, 32'h0);
      repeat (3) @(posedge clock);
      cmp(cpu_irq, 0);
      $display("conversion test done");
    end
  endtask
  task t_hold;
    begin
      apb(1'b1, ra, 32'h0);
      apb(1'b0, rh, 32'h0);
      cmp(rd, 32'h0A);
      apb(1'b1, ra, 32'h80);
      apb(1'b1, ra, 32'h0);
      apb(1'b0, ra, 32'h0);
      cmp(rd[6], 0);
      apb(1'b1, ra, 32'h20);
      repeat (26) @(posedge clock);
      apb(1'b1, ra, 32'hA0);
      repeat (40) @(posedge clock);
      apb(1'b0, ra, 32'h0);
      cmp(rd, 32'hA0);
      apb(1'b1, ra, 32'h20);
      apb(1'b0, ra, 32'h0);
      cmp(rd[6], 1);
      $display("hold test done");
    end
  endtask
  initial begin
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    t_regs;
    t_route;
    t_conv(0);
    t_conv(1);
    t_hold;
    close_out;
  end
endmodule
